// ### dma_controller.sv
// four-channel dma controller: registers, request routing, arbiter and transfer engine
`timescale 1ns/1ps
module dma_controller (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    // memory bus master, read data valid the cycle after memRead
    output logic [31:0] memAddr,
    output logic [31:0] memWrData,
    output logic [1:0] memSize,
    output logic memRead,
    output logic memWrite,
    input wire logic [31:0] memRdData,
    // peripheral request and acknowledge, index 0 spi .. 4 adc
    input wire logic [4:0] perRxReq,
    input wire logic [4:0] perTxReq,
    output logic [4:0] perRxAck,
    output logic [4:0] perTxAck,
    // interrupt
    output logic irq
);
    // engine states
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_END} state_t;

    // channel register storage
    logic [31:0] srcBase_reg [dma_pkg::NUM_CH];
    logic [31:0] dstBase_reg [dma_pkg::NUM_CH];
    logic [15:0] len_reg [dma_pkg::NUM_CH];
    logic [15:0] thr_reg [dma_pkg::NUM_CH];
    logic [15:0] idx_reg [dma_pkg::NUM_CH];
    dma_pkg::ctrl_t ctrl_reg [dma_pkg::NUM_CH];
    // global state
    logic [7:0] mux_reg;
    logic [3:0] intStat_reg;
    logic frozen_reg;
    logic [31:0] rdData_reg;
    // engine state
    state_t state_reg;
    logic [1:0] activeCh_reg;
    logic lockValid_reg;
    logic [1:0] lockCh_reg;
    dma_pkg::mem_req_t mem_reg;
    logic [31:0] data_reg;
    // handshake tracking
    logic [3:0] ackPulse_reg;
    logic [3:0] waitReady_reg;
    logic [3:0] edgePend_reg;
    logic [3:0] chReqPrev_reg;
    logic [4:0] rxAck_reg;
    logic [4:0] txAck_reg;
    logic irq_reg;
    // request synchronisers, first stage read only by second
    logic [4:0] rxMeta_reg;
    logic [4:0] rxSync_reg;
    logic [4:0] txMeta_reg;
    logic [4:0] txSync_reg;

    // register decode
    wire isGlobal = regAddr[dma_pkg::GLOBAL_BIT];
    wire [1:0] regCh = regAddr[dma_pkg::CH_FIELD_LO +: 2];
    wire [4:0] regOff = regAddr[4:0];
    wire chWr = regWrite && !isGlobal;
    wire ctrlWr = chWr && (regOff == dma_pkg::OFF_CTRL);
    wire [3:0] ctrlWrHit = ctrlWr ? (4'h1 << regCh) : 4'h0;
    wire muxWr = regWrite && (regAddr == dma_pkg::OFF_MUX);
    wire statWr = regWrite && (regAddr == dma_pkg::OFF_STAT);
    wire setFrzWr = regWrite && (regAddr == dma_pkg::OFF_SETFRZ) && regWrData[dma_pkg::FREEZE_BIT];
    wire relFrzWr = regWrite && (regAddr == dma_pkg::OFF_RELFRZ) && regWrData[dma_pkg::FREEZE_BIT];
    wire dma_pkg::ctrl_t wrCtrl = regWrData;

    // per-channel views of control fields
    logic [3:0] runVec;
    logic [3:0] trigVec;
    logic [3:0] irqEnVec;
    logic [3:0] chReq;
    logic [3:0] elig;
    logic [1:0] routeOk;

    // active channel fields and address generation
    wire dma_pkg::ctrl_t actCtrl = ctrl_reg[activeCh_reg];
    wire [15:0] actIdx = idx_reg[activeCh_reg];
    wire [1:0] actShift = (actCtrl.itemWidth > dma_pkg::WIDTH_32) ? dma_pkg::WIDTH_32 : actCtrl.itemWidth;
    wire [31:0] idxOffset = {16'h0000, actIdx} << actShift;
    wire [31:0] srcAddr = srcBase_reg[activeCh_reg] + (actCtrl.sourceStepFlag ? idxOffset : 32'h0);
    wire [31:0] dstAddr = dstBase_reg[activeCh_reg] + (actCtrl.destStepFlag ? idxOffset : 32'h0);
    wire finishNow = (actIdx == len_reg[activeCh_reg]);
    wire keepRun = actCtrl.requestTriggerSelect && actCtrl.wraparoundEnable;
    wire thrHit = (actIdx == thr_reg[activeCh_reg]);
    // locked channel may only proceed while it is eligible
    wire lockElig = elig[lockCh_reg];

    // request routing, eligibility and field views
    always_comb begin
        logic [3:0] sel0;
        logic [3:0] sel1;
        sel0 = mux_reg[3:0];
        sel1 = mux_reg[7:4];
        // lower selector wins on a clash
        routeOk[0] = sel0 < 4'(dma_pkg::NUM_PERIPH);
        routeOk[1] = (sel1 < 4'(dma_pkg::NUM_PERIPH)) && !(routeOk[0] && sel1 == sel0);
        // rx to x channel, tx to y channel
        chReq[0] = routeOk[0] && rxSync_reg[sel0[2:0]];
        chReq[1] = routeOk[0] && txSync_reg[sel0[2:0]];
        chReq[2] = routeOk[1] && rxSync_reg[sel1[2:0]];
        chReq[3] = routeOk[1] && txSync_reg[sel1[2:0]];
        for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            runVec[i] = ctrl_reg[i].run;
            trigVec[i] = ctrl_reg[i].requestTriggerSelect;
            irqEnVec[i] = ctrl_reg[i].irqEnable;
            // software trigger always ready; level; edge; stall
            if (!ctrl_reg[i].requestTriggerSelect) begin
                elig[i] = ctrl_reg[i].run && !frozen_reg;
            end else if (ctrl_reg[i].edgeSense) begin
                elig[i] = ctrl_reg[i].run && !frozen_reg && edgePend_reg[i];
            end else begin
                elig[i] = ctrl_reg[i].run && !frozen_reg && chReq[i] && !waitReady_reg[i];
            end
        end
        // a locked software copy keeps running through a freeze
        if (lockValid_reg && !ctrl_reg[lockCh_reg].requestTriggerSelect) begin
            elig[lockCh_reg] = ctrl_reg[lockCh_reg].run;
        end
    end

    // priority arbiter
    logic [1:0] pick;
    logic pickValid;
    always_comb begin
        logic [2:0] best;
        best = 3'h0;
        pick = 2'h0;
        pickValid = 1'b0;
        // strict greater keeps the lower channel on ties
        for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            if (elig[i] && (!pickValid || ctrl_reg[i].channelPriority > best)) begin
                pickValid = 1'b1;
                best = ctrl_reg[i].channelPriority;
                pick = 2'(i);
            end
        end
    end
    // a lock excludes every other channel; a software channel without yield locks
    wire [1:0] grantCh = lockValid_reg ? lockCh_reg : pick;
    wire grantNow = (state_reg == ST_IDLE) && (lockValid_reg ? lockElig : pickValid);

    // acknowledge demultiplexing back to the peripheral that owns each pair
    logic [4:0] rxAckNext;
    logic [4:0] txAckNext;
    always_comb begin
        rxAckNext = 5'h00;
        txAckNext = 5'h00;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < dma_pkg::NUM_PERIPH; k++) begin
                if (routeOk[p] && mux_reg[p*4 +: 4] == 4'(k)) begin
                    rxAckNext[k] = rxAckNext[k] | ackPulse_reg[2*p];
                    txAckNext[k] = txAckNext[k] | ackPulse_reg[2*p+1];
                end
            end
        end
    end

    // register read mux, unmapped offsets read zero
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        if (isGlobal) begin
            case (regAddr)
                dma_pkg::OFF_MUX: rdMux = {24'h0, mux_reg};
                dma_pkg::OFF_STAT: rdMux = {28'h0, intStat_reg};
                dma_pkg::OFF_SETFRZ: rdMux = 32'(frozen_reg) << dma_pkg::FREEZE_BIT;
                default: rdMux = 32'h0;
            endcase
        end else begin
            case (regOff)
                dma_pkg::OFF_SRC: rdMux = srcBase_reg[regCh];
                dma_pkg::OFF_DST: rdMux = dstBase_reg[regCh];
                dma_pkg::OFF_LEN: rdMux = {16'h0, len_reg[regCh]};
                dma_pkg::OFF_THR: rdMux = {16'h0, thr_reg[regCh]};
                dma_pkg::OFF_CTRL: rdMux = ctrl_reg[regCh];
                dma_pkg::OFF_IDX: rdMux = {16'h0, idx_reg[regCh]};
                default: rdMux = 32'h0;
            endcase
        end
    end

    // synchronisers and read data, data stands one cycle only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxMeta_reg <= 5'h00;
            rxSync_reg <= 5'h00;
            txMeta_reg <= 5'h00;
            txSync_reg <= 5'h00;
            rdData_reg <= 32'h0;
        end else begin
            rxMeta_reg <= perRxReq;
            rxSync_reg <= rxMeta_reg;
            txMeta_reg <= perTxReq;
            txSync_reg <= txMeta_reg;
            rdData_reg <= regRead ? rdMux : 32'h0;
        end
    end

    // global registers; freeze set and release
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_reg <= dma_pkg::MUX_RESET;
            frozen_reg <= 1'b0;
        end else begin
            if (muxWr) mux_reg <= regWrData[7:0];
            if (setFrzWr) frozen_reg <= 1'b1;
            else if (relFrzWr) frozen_reg <= 1'b0;
        end
    end

    // per-channel registers and handshake flags
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
                srcBase_reg[i] <= 32'h0;
                dstBase_reg[i] <= 32'h0;
                len_reg[i] <= 16'h0;
                thr_reg[i] <= 16'h0;
                idx_reg[i] <= 16'h0;
                ctrl_reg[i] <= dma_pkg::CTRL_RESET;
            end
            intStat_reg <= 4'h0;
            waitReady_reg <= 4'h0;
            edgePend_reg <= 4'h0;
            chReqPrev_reg <= 4'h0;
        end else begin
            chReqPrev_reg <= chReq;
            for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
                // peripheral ready again once its request drops
                if (!chReq[i]) waitReady_reg[i] <= 1'b0;
                // rising request edge arms the channel until it is granted
                if (chReq[i] && !chReqPrev_reg[i]) edgePend_reg[i] <= 1'b1;
                else if (grantNow && grantCh == 2'(i)) edgePend_reg[i] <= 1'b0;
            end
            // software clear of sticky status, hardware set below wins
            if (statWr) intStat_reg <= intStat_reg & ~regWrData[3:0];
            // end of item bookkeeping
            if (state_reg == ST_END) begin
                if (thrHit) intStat_reg[activeCh_reg] <= 1'b1;
                if (actCtrl.requestTriggerSelect) waitReady_reg[activeCh_reg] <= 1'b1;
                // stop at length; wraparound_enable request channel wraps
                if (finishNow) begin
                    idx_reg[activeCh_reg] <= 16'h0;
                    if (!keepRun) ctrl_reg[activeCh_reg].run <= 1'b0;
                end else begin
                    idx_reg[activeCh_reg] <= actIdx + 16'h1;
                end
            end
            // software writes last so a set of run beats the hardware clear
            if (chWr) begin
                case (regOff)
                    dma_pkg::OFF_SRC: srcBase_reg[regCh] <= regWrData;
                    dma_pkg::OFF_DST: dstBase_reg[regCh] <= regWrData;
                    dma_pkg::OFF_LEN: len_reg[regCh] <= regWrData[15:0];
                    dma_pkg::OFF_THR: thr_reg[regCh] <= regWrData[15:0];
                    dma_pkg::OFF_CTRL: begin
                        ctrl_reg[regCh] <= wrCtrl;
                        // index cleared when the channel starts
                        if (wrCtrl.run && !ctrl_reg[regCh].run) idx_reg[regCh] <= 16'h0;
                    end
                    default: ;
                endcase
            end
        end
    end

    // transfer engine: read beat, write beat, end of cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            activeCh_reg <= 2'h0;
            lockValid_reg <= 1'b0;
            lockCh_reg <= 2'h0;
            mem_reg <= dma_pkg::MEM_IDLE;
            ackPulse_reg <= 4'h0;
        end else begin
            ackPulse_reg <= 4'h0;
            mem_reg.read <= 1'b0;
            mem_reg.write <= 1'b0;
            case (state_reg)
                // a new cycle is granted whenever the start condition holds
                ST_IDLE: begin
                    if (grantNow) begin
                        activeCh_reg <= grantCh;
                        state_reg <= ST_READ;
                    end
                end
                // memory read beat at the source address, stepped only when sourceStepFlag is set
                ST_READ: begin
                    mem_reg.addr <= srcAddr;
                    // item width drives the bus size
                    mem_reg.size <= actShift;
                    mem_reg.read <= 1'b1;
                    state_reg <= ST_WRITE;
                end
                // read data arrives while the write beat is prepared
                ST_WRITE: begin
                    if (!mem_reg.read) begin
                        mem_reg.addr <= dstAddr;
                        mem_reg.wrData <= memRdData;
                        mem_reg.write <= 1'b1;
                        state_reg <= ST_END;
                    end
                end
                ST_END: begin
                    if (actCtrl.requestTriggerSelect) ackPulse_reg[activeCh_reg] <= 1'b1;
                    // software channel without yield holds; fill lock holds
                    lockValid_reg <= !(finishNow && !keepRun)
                        && (actCtrl.fillLock || (!actCtrl.requestTriggerSelect && !actCtrl.yield));
                    lockCh_reg <= activeCh_reg;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
            // a locked channel switched off by software releases the bus
            if (lockValid_reg && !ctrl_reg[lockCh_reg].run && state_reg == ST_IDLE) begin
                lockValid_reg <= 1'b0;
            end
        end
    end

    // acknowledge and interrupt outputs; status gated by enable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxAck_reg <= 5'h00;
            txAck_reg <= 5'h00;
            irq_reg <= 1'b0;
        end else begin
            rxAck_reg <= rxAckNext;
            txAck_reg <= txAckNext;
            irq_reg <= |(intStat_reg & irqEnVec);
        end
    end

    // outputs straight from flip-flops
    assign regRdData = rdData_reg;
    assign memAddr = mem_reg.addr;
    assign memWrData = mem_reg.wrData;
    assign memSize = mem_reg.size;
    assign memRead = mem_reg.read;
    assign memWrite = mem_reg.write;
    assign perRxAck = rxAck_reg;
    assign perTxAck = txAck_reg;
    assign irq = irq_reg;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_read_then_write: assert property (memRead |-> ##2 memWrite)
        else $error("write beat did not follow read by two cycles");
    a_run_auto_clear: assert property ((state_reg == ST_END && finishNow && !keepRun
        && !ctrlWrHit[activeCh_reg]) |=> !runVec[$past(activeCh_reg)])
        else $error("run bit not cleared at end of transfer");
    a_soft_start_go: assert property ((state_reg == ST_IDLE && !lockValid_reg
        && runVec[0] && !trigVec[0] && !frozen_reg) |=> state_reg == ST_READ)
        else $error("software channel did not start");
    a_level_wait: assert property ((state_reg == ST_IDLE && !lockValid_reg
        && (runVec & ~trigVec) == 4'h0 && chReq == 4'h0 && edgePend_reg == 4'h0)
        |=> state_reg == ST_IDLE)
        else $error("request channel started without request");
    a_index_start_zero: assert property ((ctrlWr && wrCtrl.run && !runVec[regCh])
        |=> idx_reg[$past(regCh)] == 16'h0)
        else $error("index not cleared at start");
    a_fixed_source: assert property ((state_reg == ST_READ && !actCtrl.sourceStepFlag)
        |=> memAddr == srcBase_reg[$past(activeCh_reg)])
        else $error("fixed source address moved");
    a_threshold_status: assert property ((state_reg == ST_END && thrHit)
        |=> intStat_reg[$past(activeCh_reg)])
        else $error("threshold status not set");
    a_top_priority: assert property ((state_reg == ST_IDLE && !lockValid_reg && elig[0]
        && ctrl_reg[0].channelPriority == dma_pkg::PRIO_TOP) |=> activeCh_reg == 2'h0)
        else $error("top priority channel lost arbitration");
    a_lock_keeps_bus: assert property ((state_reg == ST_IDLE && lockValid_reg && lockElig)
        |=> state_reg == ST_READ && activeCh_reg == $past(lockCh_reg))
        else $error("locked channel was preempted");
    a_freeze_halts: assert property ((frozen_reg && !lockValid_reg && state_reg == ST_IDLE)
        |=> state_reg == ST_IDLE)
        else $error("frozen controller started a cycle");
    a_irq_gating: assert property (irq |-> $past(|(intStat_reg & irqEnVec)))
        else $error("interrupt without enabled status");

    c_wraparound_enable_wrap: cover property (state_reg == ST_END && finishNow && keepRun);
    c_fill_lock: cover property (state_reg == ST_END && actCtrl.fillLock && !finishNow);
    c_edge_grant: cover property (grantNow && ctrl_reg[grantCh].edgeSense);
endmodule // dma_controller

// ### dma_pkg.sv
// shared constants and carrier types for the four-channel dma controller
package dma_pkg;
    // channel and peripheral counts
    localparam int NUM_CH = 4;
    localparam int NUM_PERIPH = 5;
    // per-channel register offsets, channel number sits in address bits 6:5
    localparam logic [4:0] OFF_SRC = 5'h00;
    localparam logic [4:0] OFF_DST = 5'h04;
    localparam logic [4:0] OFF_LEN = 5'h08;
    localparam logic [4:0] OFF_THR = 5'h0C;
    localparam logic [4:0] OFF_CTRL = 5'h10;
    localparam logic [4:0] OFF_IDX = 5'h14;
    localparam int CH_FIELD_LO = 5;
    localparam int GLOBAL_BIT = 7;
    // global register offsets
    localparam logic [7:0] OFF_MUX = 8'h80;
    localparam logic [7:0] OFF_STAT = 8'h84;
    localparam logic [7:0] OFF_SETFRZ = 8'h88;
    localparam logic [7:0] OFF_RELFRZ = 8'h8C;
    // freeze control bit in the set and release registers
    localparam int FREEZE_BIT = 4;
    // selector field width and reset value (reserved code, routes nothing)
    localparam int SEL_W = 4;
    localparam logic [7:0] MUX_RESET = 8'hFF;
    // item width codes and the widest byte shift
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    // top priority code
    localparam logic [2:0] PRIO_TOP = 3'h7;
    // channel control layout, run bit at bit 0
    typedef struct packed {
        logic [17:0] spare;
        logic fillLock;
        logic yield;
        logic [2:0] channelPriority;
        logic irqEnable;
        logic wraparoundEnable;
        logic edgeSense;
        logic requestTriggerSelect;
        logic destStepFlag;
        logic sourceStepFlag;
        logic [1:0] itemWidth;
        logic run;
    } ctrl_t;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // one memory bus beat as driven by the engine
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wrData;
        logic [1:0] size;
        logic read;
        logic write;
    } mem_req_t;
    localparam logic [67:0] MEM_IDLE = 68'h0;
endpackage : dma_pkg

// ### dma_partner_model.sv
// partner model: zero-wait memory and peripheral transmit request sources
`timescale 1ns/1ps
module dma_partner_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // memory side
    input wire logic [31:0] memAddr,
    input wire logic memRead,
    output logic [31:0] memRdData,
    // peripheral side, arm pulses come from the bench
    input wire logic [4:0] armTx,
    input wire logic [4:0] perTxAck,
    output logic [4:0] perTxReq
);
    // data valid only the cycle after the strobe; inverted otherwise so stale data never matches
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            memRdData <= 32'h0;
        end else begin
            memRdData <= memRead ? (memAddr ^ 32'h5A5A_0000) : ~memRdData;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            perTxReq <= 5'h00;
        end else begin
            perTxReq <= (perTxReq | armTx) & ~perTxAck;
        end
    end
endmodule // dma_partner_model

// ### tb_top.sv
// testbench for the four-channel dma controller
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, memRead, memWrite, irq;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, memAddr, memWrData, memRdData, v;
    logic [31:0] lastAddr, lastData;
    logic [1:0] memSize;
    logic [4:0] armTx = 5'h00, perTxReq, perTxAck, perRxAck;
    int numErrors = 0, nChecks = 0, wrCnt = 0, cyc = 0;
    dma_controller dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .memAddr(memAddr), .memWrData(memWrData), .memSize(memSize), .memRead(memRead),
        .memWrite(memWrite), .memRdData(memRdData), .perRxReq(5'h00), .perTxReq(perTxReq),
        .perRxAck(perRxAck), .perTxAck(perTxAck), .irq(irq));
    dma_partner_model partner (.sys_clk(sys_clk), .rst_n(rst_n), .memAddr(memAddr),
        .memRead(memRead), .memRdData(memRdData), .armTx(armTx), .perTxAck(perTxAck),
        .perTxReq(perTxReq));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // record every write beat; timeout guards against a hung engine
    always @(posedge sys_clk) begin
        cyc++;
        if (memWrite === 1'b1) begin
            wrCnt++;
            lastAddr = memAddr;
            lastData = memWrData;
        end
        if (cyc > 5000) begin
            numErrors++;
            completeRun();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 v = regRdData;
    endtask
    // bounded wait for a given number of write beats
    task automatic waitWr(input int n);
        for (int i = 0; i < 300 && wrCnt < n; i++) @(posedge sys_clk);
        chk(32'(wrCnt), 32'(n));
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(dma_pkg::OFF_MUX); chk(v, 32'h0000_00FF); // reserved selectors at reset
        rd(8'h9C); chk(v, 32'h0); // unmapped offset reads zero
        // software copy of two 32-bit items, threshold 0 with irq enabled
        wr(8'h00, 32'h0000_0100);
        wr(8'h04, 32'h0000_0200);
        wr(8'h08, 32'h0000_0001);
        wr(8'h0C, 32'h0000_0000);
        wr(8'h10, 32'h0000_011D);
        waitWr(2);
        chk(lastAddr, 32'h0000_0204);
        chk(lastData, 32'h5A5A_0104);
        chk({31'h0, irq}, 32'h1);
        chk({30'h0, memSize}, 32'h2);
        rd(8'h10); chk(v & 32'h1, 32'h0);
        rd(dma_pkg::OFF_STAT); chk(v & 32'hF, 32'h1);
        wr(dma_pkg::OFF_STAT, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        // both pairs select peripheral 1: pair 0 wins, channel 3 never moves
        wr(dma_pkg::OFF_MUX, 32'h0000_0011);
        wr(8'h20, 32'h0000_0300);
        wr(8'h24, 32'h0000_0400);
        wr(8'h28, 32'h0);
        wr(8'h2C, 32'h0000_FFFF);
        // fixed destination, it is a peripheral register
        wr(8'h30, 32'h0000_0029);
        wr(8'h70, 32'h0000_0029);
        repeat (10) @(posedge sys_clk);
        chk(32'(wrCnt), 32'd2);
        armTx <= 5'h02;
        @(posedge sys_clk);
        armTx <= 5'h00;
        waitWr(3);
        chk(lastAddr, 32'h0000_0400);
        chk({30'h0, memSize}, 32'h0);
        chk({27'h0, perTxReq}, 32'h0);
        rd(8'h70); chk(v & 32'h1, 32'h1);
        wr(8'h70, 32'h0);
        // freeze blocks a fresh start until released
        wr(dma_pkg::OFF_SETFRZ, 32'h0000_0010);
        rd(dma_pkg::OFF_SETFRZ); chk(v & 32'h10, 32'h10);
        wr(8'h50, 32'h0000_011D);
        repeat (20) @(posedge sys_clk);
        chk(32'(wrCnt), 32'd3);
        wr(dma_pkg::OFF_RELFRZ, 32'h0000_0010);
        waitWr(4);
        // fill of three words from one fixed source word, bus held throughout
        wr(8'h40, 32'h0000_0500);
        wr(8'h44, 32'h0000_0600);
        wr(8'h48, 32'h0000_0002);
        // fill lock with fixed source and stepped destination
        wr(8'h50, 32'h0000_2015);
        waitWr(7);
        chk(lastAddr, 32'h0000_0608);
        chk(lastData, 32'h5A5A_0500);
        completeRun();
    end
endmodule // tb_top
